// file: core/ssecc_regs.sv
`timescale 1ns/10ps
module ssecc_regs #(
    parameter logic [15:0] CHIP_REVISION = ssecc_pkg::SSECC_DEFAULT_REV
) (
    input  wire logic                 clk_sys,
    input  wire logic                 sys_rst,
    input  wire ssecc_pkg::ssecc_wb_req_t wb_req,
    output ssecc_pkg::ssecc_wb_rsp_t  wb_rsp,
    input  wire logic                 debug_lock_status,
    input  wire logic                 system_ram_ecc_error,
    input  wire logic                 system_ram_ecc_correctable,
    output logic                      irq_debug_unlock,
    output logic                      irq_ecc,
    output logic                      irq,
    output logic                      ecc_uncorrectable
);
    import ssecc_pkg::*;

    // =========================================================================
    // Register state
    // =========================================================================
    logic                      sys_ie_q;
    logic                      sys_ie_d;
    logic                      ecc_ie_q;
    logic                      ecc_ie_d;
    logic                      ecc_err_q;
    logic                      ecc_err_d;
    logic                      ecc_ced_q;
    logic                      ecc_ced_d;
    logic [SSECC_IRQ_BITS-1:0] irq_status_q;
    logic [SSECC_IRQ_BITS-1:0] irq_status_d;
    logic [SSECC_IRQ_BITS-1:0] irq_mask_q;
    logic [SSECC_IRQ_BITS-1:0] irq_mask_d;
    logic                      lock_prev_q;
    logic                      lock_prev_d;

    // =========================================================================
    // Bus and output state
    // =========================================================================
    ssecc_wb_rsp_t             rsp_q;
    ssecc_wb_rsp_t             rsp_d;
    logic                      irq_debug_q;
    logic                      irq_debug_d;
    logic                      irq_ecc_q;
    logic                      irq_ecc_d;
    logic                      irq_q;
    logic                      irq_d;
    logic                      uncorr_q;
    logic                      uncorr_d;

    // =========================================================================
    // Decode helpers
    // =========================================================================
    logic                      req_live;
    logic                      wr_commit;
    logic                      lane0;
    logic [SSECC_IRQ_BITS-1:0] irq_events;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction : hit

    function automatic logic [31:0] read_mux(
        input logic [7:0]                adr,
        input logic                      sys_ie,
        input logic                      ecc_err,
        input logic                      ecc_ced,
        input logic                      ecc_ie,
        input logic [SSECC_IRQ_BITS-1:0] status,
        input logic [SSECC_IRQ_BITS-1:0] mask
    );
        logic [31:0] word;
        word = SSECC_RST_WORD;
        if (hit(adr, SSECC_OFS_REVISION)) begin
            word[SSECC_REV_MSB:0] = CHIP_REVISION;
        end else if (hit(adr, SSECC_OFS_SYS_IE)) begin
            word[SSECC_FLD_BIT0] = sys_ie;
        end else if (hit(adr, SSECC_OFS_ECC_ERR)) begin
            word[SSECC_FLD_BIT0] = ecc_err;
        end else if (hit(adr, SSECC_OFS_ECC_CED)) begin
            word[SSECC_FLD_BIT0] = ecc_ced;
        end else if (hit(adr, SSECC_OFS_ECC_IE)) begin
            word[SSECC_FLD_BIT0] = ecc_ie;
        end else if (hit(adr, SSECC_OFS_IRQ_STATUS)) begin
            word[SSECC_IRQ_BITS-1:0] = status;
        end else if (hit(adr, SSECC_OFS_IRQ_MASK)) begin
            word[SSECC_IRQ_BITS-1:0] = mask;
        end
        read_mux = word;
    endfunction : read_mux

    // A write takes effect only on the edge where the master sees ack high,
    // so a request dropped early never alters state.
    assign req_live  = wb_req.cyc & wb_req.stb;
    assign wr_commit = req_live & wb_req.we & rsp_q.ack;
    assign lane0     = wb_req.sel[0];

    assign irq_events[SSECC_IRQ_DEBUG]   = debug_lock_status & ~lock_prev_q;
    assign irq_events[SSECC_IRQ_ECC_ERR] = system_ram_ecc_error;
    assign irq_events[SSECC_IRQ_ECC_CED] = system_ram_ecc_correctable;

    // =========================================================================
    // Register next-state logic
    // =========================================================================
    always_comb begin
        sys_ie_d     = sys_ie_q;
        ecc_ie_d     = ecc_ie_q;
        ecc_err_d    = ecc_err_q;
        ecc_ced_d    = ecc_ced_q;
        irq_status_d = irq_status_q;
        irq_mask_d   = irq_mask_q;
        lock_prev_d  = debug_lock_status;

        if (wr_commit && lane0) begin
            if (hit(wb_req.adr, SSECC_OFS_SYS_IE)) begin
                sys_ie_d = wb_req.dat[SSECC_FLD_BIT0];
            end
            if (hit(wb_req.adr, SSECC_OFS_ECC_IE)) begin
                ecc_ie_d = wb_req.dat[SSECC_FLD_BIT0];
            end
            if (hit(wb_req.adr, SSECC_OFS_ECC_ERR) && wb_req.dat[SSECC_FLD_BIT0]) begin
                ecc_err_d = 1'b0;
            end
            if (hit(wb_req.adr, SSECC_OFS_ECC_CED) && wb_req.dat[SSECC_FLD_BIT0]) begin
                ecc_ced_d = 1'b0;
            end
            if (hit(wb_req.adr, SSECC_OFS_IRQ_STATUS)) begin
                irq_status_d = irq_status_q & ~wb_req.dat[SSECC_IRQ_BITS-1:0];
            end
            if (hit(wb_req.adr, SSECC_OFS_IRQ_MASK)) begin
                irq_mask_d = wb_req.dat[SSECC_IRQ_BITS-1:0];
            end
        end

        // Events are applied after clears so a coincident event is never lost.
        if (system_ram_ecc_error) begin
            ecc_err_d = 1'b1;
        end
        if (system_ram_ecc_correctable) begin
            ecc_ced_d = 1'b1;
        end
        irq_status_d = irq_status_d | irq_events;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sys_ie_q     <= SSECC_RST_BIT;
            ecc_ie_q     <= SSECC_RST_BIT;
            ecc_err_q    <= SSECC_RST_BIT;
            ecc_ced_q    <= SSECC_RST_BIT;
            irq_status_q <= SSECC_RST_IRQ;
            irq_mask_q   <= SSECC_RST_IRQ;
            lock_prev_q  <= SSECC_RST_BIT;
        end else begin
            sys_ie_q     <= sys_ie_d;
            ecc_ie_q     <= ecc_ie_d;
            ecc_err_q    <= ecc_err_d;
            ecc_ced_q    <= ecc_ced_d;
            irq_status_q <= irq_status_d;
            irq_mask_q   <= irq_mask_d;
            lock_prev_q  <= lock_prev_d;
        end
    end

    // =========================================================================
    // Bus response next-state logic
    // =========================================================================
    // Every address answers; unmapped ones read zero and drop writes, which
    // keeps a stray access from hanging the bus.
    always_comb begin
        rsp_d.ack = req_live & ~rsp_q.ack;
        rsp_d.dat = rsp_q.dat;
        if (req_live && !rsp_q.ack) begin
            rsp_d.dat = read_mux(wb_req.adr, sys_ie_q, ecc_err_q, ecc_ced_q,
                                 ecc_ie_q, irq_status_q, irq_mask_q);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rsp_q.ack <= SSECC_RST_BIT;
            rsp_q.dat <= SSECC_RST_WORD;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    // =========================================================================
    // Interrupt and status outputs
    // =========================================================================
    always_comb begin
        irq_debug_d = sys_ie_q & debug_lock_status;
        irq_ecc_d   = ecc_ie_q & ecc_err_q;
        irq_d       = |(irq_status_q & irq_mask_q);
        uncorr_d    = ecc_err_q & ~ecc_ced_q;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_debug_q <= SSECC_RST_BIT;
            irq_ecc_q   <= SSECC_RST_BIT;
            irq_q       <= SSECC_RST_BIT;
            uncorr_q    <= SSECC_RST_BIT;
        end else begin
            irq_debug_q <= irq_debug_d;
            irq_ecc_q   <= irq_ecc_d;
            irq_q       <= irq_d;
            uncorr_q    <= uncorr_d;
        end
    end

    assign wb_rsp            = rsp_q;
    assign irq_debug_unlock  = irq_debug_q;
    assign irq_ecc           = irq_ecc_q;
    assign irq               = irq_q;
    assign ecc_uncorrectable = uncorr_q;

endmodule : ssecc_regs

// file: inc/ssecc_pkg.sv
// =============================================================================
// Notes on behaviour
// - Revision register returns packed BCD revision in bits 15:0; upper half reads zero.
// - Debug-unlock enable resets to zero; when set, interrupt follows debug lock status.
// - ECC error flag sets on system RAM ECC error, holds until one written.
// - Correctable flag sets on single correctable ECC error in system RAM bank.
// - Correctable flag clears on writing one to bit 0, survives reads.
// - Error flag set with correctable flag clear means an uncorrectable error.
// - ECC interrupt enable is read/write, resets zero, gates the ECC error interrupt.
// =============================================================================
package ssecc_pkg;

    // =========================================================================
    // Register map
    // =========================================================================
    localparam logic [7:0] SSECC_OFS_REVISION   = 8'h50;
    localparam logic [7:0] SSECC_OFS_SYS_IE     = 8'h54;
    localparam logic [7:0] SSECC_OFS_ECC_ERR    = 8'h64;
    localparam logic [7:0] SSECC_OFS_ECC_CED    = 8'h68;
    localparam logic [7:0] SSECC_OFS_ECC_IE     = 8'h6C;
    localparam logic [7:0] SSECC_OFS_IRQ_STATUS = 8'h78;
    localparam logic [7:0] SSECC_OFS_IRQ_MASK   = 8'h7C;

    // =========================================================================
    // Field positions and reset values
    // =========================================================================
    localparam int         SSECC_FLD_BIT0       = 0;
    localparam int         SSECC_REV_MSB        = 15;
    localparam int         SSECC_IRQ_BITS       = 3;
    localparam int         SSECC_IRQ_DEBUG      = 0;
    localparam int         SSECC_IRQ_ECC_ERR    = 1;
    localparam int         SSECC_IRQ_ECC_CED    = 2;
    localparam logic       SSECC_RST_BIT        = 1'b0;
    localparam logic [2:0] SSECC_RST_IRQ        = 3'h0;
    localparam logic [31:0] SSECC_RST_WORD      = 32'h0000_0000;

    // Arbitrary neutral revision code; the real part supplies its own.
    localparam logic [15:0] SSECC_DEFAULT_REV   = 16'h0010;

    // =========================================================================
    // Bus carriers
    // =========================================================================
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } ssecc_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } ssecc_wb_rsp_t;

endpackage : ssecc_pkg

// file: testbench/ssecc_regs_properties.sv
`timescale 1ns/10ps
module ssecc_props #(
    parameter logic [15:0] CHIP_REVISION = ssecc_pkg::SSECC_DEFAULT_REV
) (
    input wire logic                     clk_sys,
    input wire logic                     sys_rst,
    input wire ssecc_pkg::ssecc_wb_req_t wb_req,
    input wire ssecc_pkg::ssecc_wb_rsp_t wb_rsp,
    input wire logic                     debug_lock_status,
    input wire logic                     system_ram_ecc_error,
    input wire logic                     system_ram_ecc_correctable,
    input wire logic                     irq_debug_unlock,
    input wire logic                     irq_ecc,
    input wire logic                     irq,
    input wire logic                     ecc_uncorrectable
);
    import ssecc_pkg::*;
    // =========================================================================
    // Shadow flags
    // =========================================================================
    // A set and a clear in one cycle keep the flag, so no event is lost.
    logic err_q, err_d, ced_q, ced_d, clr, rd;
    logic sie_q, sie_d, eie_q, eie_d, wr;
    always_comb begin
        wr = wb_rsp.ack & wb_req.cyc & wb_req.stb & wb_req.we & wb_req.sel[0];
        clr = wr & wb_req.dat[0];
        sie_d = (wr && wb_req.adr[7:2] == SSECC_OFS_SYS_IE[7:2]) ? wb_req.dat[0] : sie_q;
        eie_d = (wr && wb_req.adr[7:2] == SSECC_OFS_ECC_IE[7:2]) ? wb_req.dat[0] : eie_q;
        rd = wb_rsp.ack & wb_req.cyc & wb_req.stb & ~wb_req.we;
        err_d = system_ram_ecc_error |
                (err_q & ~(clr & wb_req.adr[7:2] == SSECC_OFS_ECC_ERR[7:2]));
        ced_d = system_ram_ecc_correctable |
                (ced_q & ~(clr & wb_req.adr[7:2] == SSECC_OFS_ECC_CED[7:2]));
    end
    always_ff @(posedge clk_sys) begin
        err_q <= sys_rst ? 1'b0 : err_d;
        ced_q <= sys_rst ? 1'b0 : ced_d;
        sie_q <= sys_rst ? 1'b0 : sie_d;
        eie_q <= sys_rst ? 1'b0 : eie_d;
    end
    // =========================================================================
    // Properties
    // =========================================================================
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence s_ack_pulse;
        wb_rsp.ack ##1 !wb_rsp.ack;
    endsequence
    a_ack_single: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> s_ack_pulse)
        else $error("ack not a single pulse after request");
    a_rev_value: assert property (
        rd && wb_req.adr[7:2] == SSECC_OFS_REVISION[7:2] |-> wb_rsp.dat == {16'h0000, CHIP_REVISION})
        else $error("revision read wrong");
    a_err_readback: assert property (
        rd && wb_req.adr[7:2] == SSECC_OFS_ECC_ERR[7:2] |-> wb_rsp.dat == {31'h0, $past(err_q)})
        else $error("error flag read wrong");
    a_ced_readback: assert property (
        rd && wb_req.adr[7:2] == SSECC_OFS_ECC_CED[7:2] |-> wb_rsp.dat == {31'h0, $past(ced_q)})
        else $error("correctable flag read wrong");
    a_uncorr_flag: assert property (ecc_uncorrectable == $past(err_q && !ced_q))
        else $error("uncorrectable indication wrong");
    a_ecc_irq_gate: assert property (irq_ecc == $past(err_q && eie_q))
        else $error("ECC interrupt not enable AND flag");
    a_lock_irq_gate: assert property (irq_debug_unlock == $past(sie_q && debug_lock_status))
        else $error("debug interrupt not enable AND lock status");
    a_unmapped_zero: assert property (rd && wb_req.adr == 8'h40 |-> wb_rsp.dat == 32'h0)
        else $error("unmapped read not zero");
    a_ie_reserved: assert property (
        rd && wb_req.adr[7:2] == SSECC_OFS_SYS_IE[7:2] |-> wb_rsp.dat[31:1] == 31'h0)
        else $error("reserved enable bits not zero");
endmodule : ssecc_props

bind ssecc_regs ssecc_props #(.CHIP_REVISION(CHIP_REVISION)) u_ssecc_props (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .debug_lock_status(debug_lock_status), .system_ram_ecc_error(system_ram_ecc_error),
    .system_ram_ecc_correctable(system_ram_ecc_correctable),
    .irq_debug_unlock(irq_debug_unlock), .irq_ecc(irq_ecc), .irq(irq),
    .ecc_uncorrectable(ecc_uncorrectable));

// file: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
    import ssecc_pkg::*;
    // Arbitrary revision value for this bench.
    localparam logic [15:0] REV = 16'h0123;
    logic clk_sys = 1'b0, sys_rst = 1'b1, lock = 1'b0, err_ev = 1'b0, ced_ev = 1'b0;
    ssecc_wb_req_t wb_req = '0;
    ssecc_wb_rsp_t wb_rsp;
    logic irq_dbg, irq_ecc, irq, uncorr;
    logic [31:0] rd;
    logic [3:0] wr_sel = 4'hF;
    int failures = 0, comparisons = 0;
    always #12.5 clk_sys = ~clk_sys;
    ssecc_regs #(.CHIP_REVISION(REV)) u_ssecc_regs (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .wb_req(wb_req), .wb_rsp(wb_rsp), .debug_lock_status(lock),
        .system_ram_ecc_error(err_ev), .system_ram_ecc_correctable(ced_ev),
        .irq_debug_unlock(irq_dbg), .irq_ecc(irq_ecc), .irq(irq), .ecc_uncorrectable(uncorr));
    task test_done;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // The request is held until the edge that samples ack, as a classic master must.
    task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: wr_sel, dat: d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 20);
        if (wb_rsp.ack !== 1'b1) begin
            failures++;
            $display("ERROR %0t: no ack from register bus", $time);
            test_done();
        end
        rd = wb_rsp.dat;
        wb_req <= '0;
    endtask : bus
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdchk
    task pulse(input logic e, input logic c);
        @(posedge clk_sys);
        err_ev <= e;
        ced_ev <= c;
        @(posedge clk_sys);
        err_ev <= 1'b0;
        ced_ev <= 1'b0;
    endtask : pulse
    task settle;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : settle
    task t_reset;
        rdchk(SSECC_OFS_REVISION, {16'h0000, REV});
        rdchk(SSECC_OFS_SYS_IE, 32'h0);
        rdchk(SSECC_OFS_ECC_ERR, 32'h0);
        rdchk(SSECC_OFS_ECC_CED, 32'h0);
        rdchk(SSECC_OFS_ECC_IE, 32'h0);
        rdchk(SSECC_OFS_IRQ_STATUS, 32'h0);
        rdchk(SSECC_OFS_IRQ_MASK, 32'h0);
        chk({28'h0, irq_dbg, irq_ecc, irq, uncorr}, 32'h0);
        $display("t_reset done");
    endtask : t_reset
    task t_ro;
        bus(1'b1, SSECC_OFS_REVISION, 32'hFFFF_FFFF);
        rdchk(SSECC_OFS_REVISION, {16'h0000, REV});
        bus(1'b1, 8'h40, 32'hFFFF_FFFF);
        rdchk(8'h40, 32'h0);
        wr_sel = 4'hE;
        bus(1'b1, SSECC_OFS_SYS_IE, 32'h1);
        wr_sel = 4'hF;
        rdchk(SSECC_OFS_SYS_IE, 32'h0);
        bus(1'b1, SSECC_OFS_SYS_IE, 32'hFFFF_FFFF);
        rdchk(SSECC_OFS_SYS_IE, 32'h1);
        bus(1'b1, SSECC_OFS_SYS_IE, 32'h0);
        $display("t_ro done");
    endtask : t_ro
    task t_debug;
        @(posedge clk_sys);
        lock <= 1'b1;
        settle();
        chk({31'h0, irq_dbg}, 32'h0);
        bus(1'b1, SSECC_OFS_SYS_IE, 32'h1);
        settle();
        chk({31'h0, irq_dbg}, 32'h1);
        @(posedge clk_sys);
        lock <= 1'b0;
        settle();
        chk({31'h0, irq_dbg}, 32'h0);
        $display("t_debug done");
    endtask : t_debug
    task t_ecc;
        pulse(1'b1, 1'b1);
        settle();
        rdchk(SSECC_OFS_ECC_ERR, 32'h1);
        rdchk(SSECC_OFS_ECC_CED, 32'h1);
        chk({31'h0, uncorr}, 32'h0);
        bus(1'b1, SSECC_OFS_ECC_CED, 32'h0);
        bus(1'b1, SSECC_OFS_ECC_ERR, 32'h0);
        rdchk(SSECC_OFS_ECC_CED, 32'h1);
        rdchk(SSECC_OFS_ECC_ERR, 32'h1);
        bus(1'b1, SSECC_OFS_ECC_CED, 32'h1);
        rdchk(SSECC_OFS_ECC_CED, 32'h0);
        settle();
        chk({30'h0, uncorr, irq_ecc}, 32'h2);
        bus(1'b1, SSECC_OFS_ECC_IE, 32'h1);
        rdchk(SSECC_OFS_ECC_IE, 32'h1);
        settle();
        chk({31'h0, irq_ecc}, 32'h1);
        bus(1'b1, SSECC_OFS_ECC_ERR, 32'h1);
        rdchk(SSECC_OFS_ECC_ERR, 32'h0);
        settle();
        chk({30'h0, uncorr, irq_ecc}, 32'h0);
        $display("t_ecc done");
    endtask : t_ecc
    task t_irq;
        rdchk(SSECC_OFS_IRQ_STATUS, 32'h7);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, SSECC_OFS_IRQ_MASK, 32'h2);
        settle();
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, SSECC_OFS_IRQ_STATUS, 32'h7);
        pulse(1'b0, 1'b1);
        settle();
        chk({31'h0, irq}, 32'h0);
        rdchk(SSECC_OFS_IRQ_STATUS, 32'h4);
        $display("t_irq done");
    endtask : t_irq
    // Events are held high across the clearing writes, so set and clear meet.
    task t_race;
        @(posedge clk_sys);
        err_ev <= 1'b1;
        ced_ev <= 1'b1;
        bus(1'b1, SSECC_OFS_ECC_ERR, 32'h1);
        bus(1'b1, SSECC_OFS_ECC_CED, 32'h1);
        bus(1'b1, SSECC_OFS_IRQ_STATUS, 32'h7);
        err_ev <= 1'b0;
        ced_ev <= 1'b0;
        rdchk(SSECC_OFS_ECC_ERR, 32'h1);
        rdchk(SSECC_OFS_ECC_CED, 32'h1);
        rdchk(SSECC_OFS_IRQ_STATUS, 32'h6);
        bus(1'b1, SSECC_OFS_ECC_ERR, 32'h1);
        bus(1'b1, SSECC_OFS_ECC_CED, 32'h1);
        rdchk(SSECC_OFS_ECC_ERR, 32'h0);
        rdchk(SSECC_OFS_ECC_CED, 32'h0);
        $display("t_race done");
    endtask : t_race
    initial begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_ro();
        t_debug();
        t_ecc();
        t_irq();
        t_race();
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        test_done();
    end
endmodule : testbench
